/* File: verilog/spreading_code_config.sv */
// spreading code configuration registers, serial port and synthesizer settle sequencer
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - 32-chip normal rate: half select 1 picks upper 32 code bits, 0 the lower.
// - half select matters only while 32-chip normal rate codes are selected.
// - lock bypass 1: skip lock indication, wait settle count in 2 us units.
// - lock bypass 0: wait for lock, then the settle count.
// - override 0: baseband switches amplifier; override 1: amplifier follows amp-on bit.
// - amp-on bit drives amplifier only while override is 1.
// - chips-per-bit bit 1 selects 32-chip codes, 0 selects 64-chip codes.
// - double rate: two bits per code period, even bit counts; else one.
// - double rate applies only with 32-chip codes.
// - double rate splits the stored 64-chip code into two 32-chip halves.
// - normal rate 32-chip mode offers two different 32-chip codes to correlators.
// - oversampling bit 1 gives 12x, 0 gives 6x.
// - 12x only with 32-chip normal rate; otherwise the bit is ignored.
// - 64-bit code spans eight addresses, lowest address least significant byte.
module spreading_code_config (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial register port
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic spi_ss_n,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  // synthesizer
  input wire logic synth_lock,
  // baseband configuration
  output logic chips_32,
  output logic double_rate,
  output logic oversample_12x,
  output logic [1:0] bits_per_period,
  output logic [31:0] code_a,
  output logic [31:0] code_b,
  output logic [63:0] code_full,
  // radio path
  output logic rx_enable,
  output logic tx_enable,
  output logic path_release,
  output logic amp_enable
);
  localparam int DIV_W = $clog2(spreading_code_config_pkg::SETTLE_UNIT_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST =
    DIV_W'(spreading_code_config_pkg::SETTLE_UNIT_CYCLES - 1);

  logic sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, ss_s1, ss_s2, lock_s1, lock_s2;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_q;
  logic [7:0] tx_q;
  logic first_q, is_write_q;
  logic [5:0] addr_q;
  logic [7:0] ctrl_q, cfg_q, settle_cnt_q;
  logic [7:0] code_q [8];
  logic [63:0] code_word;
  spreading_code_config_pkg::seq_state_e state_q;
  logic [7:0] settle_left_q;
  logic [DIV_W-1:0] div_q;
  logic selected, sck_rise, sck_fall, byte_done, wr_en, run;
  logic [7:0] wr_data;

  // pin synchronisers
  always_ff @(posedge mclk) begin
    if (rst) begin
      {sck_s3, sck_s2, sck_s1} <= 3'h0;
      {mosi_s2, mosi_s1} <= 2'h0;
      {ss_s2, ss_s1} <= 2'h3;
      {lock_s2, lock_s1} <= 2'h0;
    end else begin
      {sck_s3, sck_s2, sck_s1} <= {sck_s2, sck_s1, spi_sck};
      {mosi_s2, mosi_s1} <= {mosi_s1, spi_mosi};
      {ss_s2, ss_s1} <= {ss_s1, spi_ss_n};
      {lock_s2, lock_s1} <= {lock_s1, synth_lock};
    end
  end

  assign selected = ~ss_s2;
  assign sck_rise = selected & sck_s2 & ~sck_s3;
  assign sck_fall = selected & ~sck_s2 & sck_s3;
  assign byte_done = sck_rise & (bit_cnt_q == 3'h7);
  assign wr_data = {rx_q, mosi_s2};
  assign wr_en = byte_done & ~first_q & is_write_q;
  assign run = ctrl_q[spreading_code_config_pkg::CTRL_RX_ENABLE] |
               ctrl_q[spreading_code_config_pkg::CTRL_TX_ENABLE];

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      code_word[8*i +: 8] = code_q[i];
    end
  end

  function automatic logic in_code(input logic [5:0] a);
    return a >= spreading_code_config_pkg::ADDR_SPREADING_CODE_LO &&
           a <= spreading_code_config_pkg::ADDR_SPREADING_CODE_HI;
  endfunction : in_code

  function automatic logic [7:0] reg_read(input logic [5:0] a);
    logic [2:0] idx;
    idx = 3'(a - spreading_code_config_pkg::ADDR_SPREADING_CODE_LO);
    if (a == spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL) return ctrl_q;
    if (a == spreading_code_config_pkg::ADDR_SPREADING_CONFIG) return cfg_q;
    if (a == spreading_code_config_pkg::ADDR_SYNTH_SETTLE_COUNT) return settle_cnt_q;
    if (in_code(a)) return code_q[idx];
    return 8'h00;
  endfunction : reg_read

  // serial byte framing: command byte, then data bytes at rising addresses
  always_ff @(posedge mclk) begin
    if (rst) begin
      bit_cnt_q <= 3'h0;
      rx_q <= 7'h00;
      tx_q <= 8'h00;
      first_q <= 1'b1;
      is_write_q <= 1'b0;
      addr_q <= 6'h00;
    end else if (!selected) begin
      bit_cnt_q <= 3'h0;
      first_q <= 1'b1;
    end else if (sck_rise) begin
      rx_q <= wr_data[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
      tx_q <= {tx_q[6:0], 1'b0};
      if (byte_done && first_q) begin
        first_q <= 1'b0;
        is_write_q <= wr_data[spreading_code_config_pkg::CMD_WRITE_BIT];
        addr_q <= wr_data[5:0];
        tx_q <= reg_read(wr_data[5:0]);
      end else if (byte_done) begin
        addr_q <= addr_q + 6'h01;
        tx_q <= reg_read(addr_q + 6'h01);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      spi_miso_oe_n <= ~selected;
      if (sck_fall) spi_miso <= tx_q[7];
    end
  end

  // register writes; reserved bits are held at zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= spreading_code_config_pkg::CTRL_RESET;
      cfg_q <= spreading_code_config_pkg::CFG_RESET;
      settle_cnt_q <= spreading_code_config_pkg::SETTLE_COUNT_RESET;
      for (int i = 0; i < 8; i++) begin
        code_q[i] <= spreading_code_config_pkg::SPREADING_CODE_RESET[8*i +: 8];
      end
    end else if (wr_en) begin
      if (addr_q == spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL)
        ctrl_q <= wr_data & spreading_code_config_pkg::CTRL_WRITE_MASK;
      if (addr_q == spreading_code_config_pkg::ADDR_SPREADING_CONFIG)
        cfg_q <= wr_data & spreading_code_config_pkg::CFG_WRITE_MASK;
      if (addr_q == spreading_code_config_pkg::ADDR_SYNTH_SETTLE_COUNT)
        settle_cnt_q <= wr_data;
      if (in_code(addr_q))
        code_q[3'(addr_q - spreading_code_config_pkg::ADDR_SPREADING_CODE_LO)] <= wr_data;
    end
  end

  // effective baseband configuration
  always_ff @(posedge mclk) begin
    if (rst) begin
      chips_32 <= 1'b0;
      double_rate <= 1'b0;
      oversample_12x <= 1'b0;
      bits_per_period <= 2'h1;
      code_a <= 32'h0000_0000;
      code_b <= 32'h0000_0000;
      code_full <= 64'h0000_0000_0000_0000;
    end else begin
      code_full <= code_word;
      chips_32 <= cfg_q[spreading_code_config_pkg::CFG_CHIPS_32];
      double_rate <= cfg_q[spreading_code_config_pkg::CFG_CHIPS_32] &
                     cfg_q[spreading_code_config_pkg::CFG_DOUBLE_RATE];
      bits_per_period <= (cfg_q[spreading_code_config_pkg::CFG_CHIPS_32] &
                          cfg_q[spreading_code_config_pkg::CFG_DOUBLE_RATE]) ? 2'h2 : 2'h1;
      oversample_12x <= cfg_q[spreading_code_config_pkg::CFG_CHIPS_32] &
                        ~cfg_q[spreading_code_config_pkg::CFG_DOUBLE_RATE] &
                        cfg_q[spreading_code_config_pkg::CFG_OVERSAMPLE_12X];
      if (!cfg_q[spreading_code_config_pkg::CFG_CHIPS_32]) begin
        code_a <= code_word[31:0];
        code_b <= code_word[63:32];
      end else if (cfg_q[spreading_code_config_pkg::CFG_DOUBLE_RATE]) begin
        code_a <= code_word[31:0];
        code_b <= code_word[63:32];
      end else if (ctrl_q[spreading_code_config_pkg::CTRL_CODE_HALF_SELECT]) begin
        code_a <= code_word[63:32];
        code_b <= code_word[31:0];
      end else begin
        code_a <= code_word[31:0];
        code_b <= code_word[63:32];
      end
    end
  end

  // synthesizer settle sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= spreading_code_config_pkg::S_IDLE;
    end else if (!run) begin
      state_q <= spreading_code_config_pkg::S_IDLE;
    end else begin
      unique case (state_q)
        spreading_code_config_pkg::S_IDLE: begin
          state_q <= ctrl_q[spreading_code_config_pkg::CTRL_LOCK_BYPASS] ?
                     spreading_code_config_pkg::S_SETTLE :
                     spreading_code_config_pkg::S_WAIT_LOCK;
        end
        spreading_code_config_pkg::S_WAIT_LOCK: begin
          if (lock_s2) state_q <= spreading_code_config_pkg::S_SETTLE;
        end
        spreading_code_config_pkg::S_SETTLE: begin
          if (settle_left_q == 8'h00) state_q <= spreading_code_config_pkg::S_READY;
        end
        spreading_code_config_pkg::S_READY: begin
          state_q <= spreading_code_config_pkg::S_READY;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      settle_left_q <= 8'h00;
      div_q <= '0;
    end else if (state_q != spreading_code_config_pkg::S_SETTLE) begin
      settle_left_q <= settle_cnt_q;
      div_q <= '0;
    end else if (div_q == DIV_LAST) begin
      div_q <= '0;
      if (settle_left_q != 8'h00) settle_left_q <= settle_left_q - 8'h01;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
      path_release <= 1'b0;
      amp_enable <= 1'b0;
    end else begin
      rx_enable <= ctrl_q[spreading_code_config_pkg::CTRL_RX_ENABLE];
      tx_enable <= ctrl_q[spreading_code_config_pkg::CTRL_TX_ENABLE];
      path_release <= run && state_q == spreading_code_config_pkg::S_READY;
      amp_enable <= ctrl_q[spreading_code_config_pkg::CTRL_AMP_OVERRIDE] ?
                    ctrl_q[spreading_code_config_pkg::CTRL_AMP_ON_REQUEST] :
                    (ctrl_q[spreading_code_config_pkg::CTRL_TX_ENABLE] & path_release);
    end
  end

  // checks
  property p_half_upper;
    @(posedge mclk) disable iff (rst)
    (cfg_q[2] && !cfg_q[1] && ctrl_q[5]) |=> (code_a == $past(code_word[63:32]) &&
                                              code_b == $past(code_word[31:0]));
  endproperty
  a_half_upper: assert property (p_half_upper) else $error("upper half not selected");

  property p_half_ignored;
    @(posedge mclk) disable iff (rst)
    !cfg_q[2] |=> (code_a == $past(code_word[31:0]) && !chips_32);
  endproperty
  a_half_ignored: assert property (p_half_ignored) else $error("half select not ignored");

  sequence s_start_bypassed;
    state_q == spreading_code_config_pkg::S_IDLE && run && ctrl_q[4];
  endsequence
  property p_bypass;
    @(posedge mclk) disable iff (rst)
    s_start_bypassed ##1 run |-> state_q == spreading_code_config_pkg::S_SETTLE;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not skip lock wait");

  property p_wait_lock;
    @(posedge mclk) disable iff (rst)
    (state_q == spreading_code_config_pkg::S_WAIT_LOCK && !lock_s2)
      |=> state_q != spreading_code_config_pkg::S_SETTLE;
  endproperty
  a_wait_lock: assert property (p_wait_lock) else $error("settle began without lock");

  property p_amp_override;
    @(posedge mclk) disable iff (rst)
    ctrl_q[3] |=> amp_enable == $past(ctrl_q[2]);
  endproperty
  a_amp_override: assert property (p_amp_override) else $error("amp not following bit");

  property p_amp_auto;
    @(posedge mclk) disable iff (rst)
    !ctrl_q[3] |=> amp_enable == $past(ctrl_q[6] && path_release);
  endproperty
  a_amp_auto: assert property (p_amp_auto) else $error("amp not under baseband control");

  property p_rate;
    @(posedge mclk) disable iff (rst)
    1'b1 |=> (bits_per_period == (($past(cfg_q[2]) && $past(cfg_q[1])) ? 2'h2 : 2'h1) &&
              double_rate == ($past(cfg_q[2]) && $past(cfg_q[1])));
  endproperty
  a_rate: assert property (p_rate) else $error("bits per code period wrong");

  property p_oversample;
    @(posedge mclk) disable iff (rst)
    (!cfg_q[2] || cfg_q[1]) |=> !oversample_12x;
  endproperty
  a_oversample: assert property (p_oversample) else $error("12x outside 32-chip normal rate");

  sequence s_unit_elapsed;
    state_q == spreading_code_config_pkg::S_SETTLE && div_q == DIV_LAST && settle_left_q != 8'h00;
  endsequence
  property p_countdown;
    @(posedge mclk) disable iff (rst)
    s_unit_elapsed |=> settle_left_q == $past(settle_left_q) - 8'h01;
  endproperty
  a_countdown: assert property (p_countdown) else $error("settle count not decremented");

  property p_release;
    @(posedge mclk) disable iff (rst)
    (state_q == spreading_code_config_pkg::S_SETTLE && settle_left_q == 8'h00 && run) ##1 run
      |=> path_release;
  endproperty
  a_release: assert property (p_release) else $error("path not released at zero");
endmodule : spreading_code_config

`default_nettype wire

/* File: common/spreading_code_config_pkg.sv */
// constants for the spreading code configuration block
package spreading_code_config_pkg;
  // register byte addresses on the serial port
  localparam logic [5:0] ADDR_RADIO_MODE_CONTROL = 6'h03;
  localparam logic [5:0] ADDR_SPREADING_CONFIG = 6'h04;
  localparam logic [5:0] ADDR_SPREADING_CODE_LO = 6'h11;
  localparam logic [5:0] ADDR_SPREADING_CODE_HI = 6'h18;
  localparam logic [5:0] ADDR_SYNTH_SETTLE_COUNT = 6'h38;

  // radio_mode_control fields
  localparam int CTRL_RX_ENABLE = 7;
  localparam int CTRL_TX_ENABLE = 6;
  localparam int CTRL_CODE_HALF_SELECT = 5;
  localparam int CTRL_LOCK_BYPASS = 4;
  localparam int CTRL_AMP_OVERRIDE = 3;
  localparam int CTRL_AMP_ON_REQUEST = 2;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hFC;

  // spreading_config fields
  localparam int CFG_CHIPS_32 = 2;
  localparam int CFG_DOUBLE_RATE = 1;
  localparam int CFG_OVERSAMPLE_12X = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h07;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] SETTLE_COUNT_RESET = 8'h64;
  localparam logic [63:0] SPREADING_CODE_RESET = 64'h1E8B_6A3D_E0E9_B222;

  // serial command byte: bit 7 set means write, bits 5:0 the start address
  localparam int CMD_WRITE_BIT = 7;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_UNIT_NS = 2000;
  localparam int SETTLE_UNIT_CYCLES = (SETTLE_UNIT_NS / CLK_PERIOD_NS > 0) ?
                                      SETTLE_UNIT_NS / CLK_PERIOD_NS : 1;

  typedef enum logic [1:0] {S_IDLE, S_WAIT_LOCK, S_SETTLE, S_READY} seq_state_e;
endpackage : spreading_code_config_pkg

/* File: bench/host_spi_model.sv */
// host model: serial register port master, mode 0, msb first
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
  // clock
  input wire logic mclk,
  // serial port
  output logic spi_sck,
  output logic spi_mosi,
  output logic spi_ss_n,
  input wire logic spi_miso
);
  // each sck phase lasts 5 mclk, above the 3 mclk minimum
  localparam int HALF = 5;

  initial begin
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    spi_ss_n = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_clk

  task automatic begin_frame();
    @(posedge mclk);
    spi_ss_n <= 1'b0;
    wait_clk(HALF);
  endtask : begin_frame

  // data changes while sck is low, read data taken at the rising edge
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= tx[i];
      spi_sck <= 1'b0;
      wait_clk(HALF);
      spi_sck <= 1'b1;
      rx = {rx[6:0], spi_miso};
      wait_clk(HALF);
    end
  endtask : xfer_byte

  // released data line shows the inverse so a stale bit is never trusted
  task automatic end_frame();
    spi_sck <= 1'b0;
    wait_clk(HALF);
    spi_ss_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    wait_clk(2 * HALF);
  endtask : end_frame
endmodule : host_spi_model
`default_nettype wire

/* File: bench/spreading_code_config_tb_top.sv */
// testbench for the spreading code configuration block
`timescale 1ns/1ps
`default_nettype none
module spreading_code_config_tb_top;
  logic mclk, rst, spi_sck, spi_mosi, spi_ss_n, spi_miso, spi_miso_oe_n, synth_lock;
  logic chips_32, double_rate, oversample_12x, rx_enable, tx_enable, path_release, amp_enable;
  logic [1:0] bits_per_period;
  logic [31:0] code_a, code_b;
  logic [63:0] code_full, code;
  logic [7:0] v, cfg;
  logic sel_hi;
  int err_total, total_checks, n;

  spreading_code_config DUT (.mclk(mclk), .rst(rst), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_ss_n(spi_ss_n), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
    .synth_lock(synth_lock), .chips_32(chips_32), .double_rate(double_rate),
    .oversample_12x(oversample_12x), .bits_per_period(bits_per_period), .code_a(code_a),
    .code_b(code_b), .code_full(code_full), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .path_release(path_release), .amp_enable(amp_enable));

  host_spi_model host (.mclk(mclk), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_ss_n(spi_ss_n), .spi_miso(spi_miso));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // burst write of nb bytes, least significant byte first
  task automatic wr_n(input logic [5:0] a, input logic [63:0] d, input int nb);
    logic [7:0] rx;
    host.begin_frame();
    host.xfer_byte({2'b10, a}, rx);
    for (int i = 0; i < nb; i++) host.xfer_byte(d[8*i +: 8], rx);
    host.end_frame();
  endtask : wr_n

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    logic [7:0] rx;
    host.begin_frame();
    host.xfer_byte({2'b00, a}, rx);
    host.xfer_byte(8'h00, d);
    host.end_frame();
  endtask : rd

  task automatic wait_rel(output int c);
    c = 0;
    while (path_release !== 1'b1 && c < 4000) begin
      @(posedge mclk);
      c++;
    end
  endtask : wait_rel

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    give_verdict();
  end

  initial begin
    err_total = 0;
    total_checks = 0;
    rst = 1'b1;
    synth_lock = 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check(code_full, spreading_code_config_pkg::SPREADING_CODE_RESET);
    check(spi_miso_oe_n, 1'b1);
    check(bits_per_period, 2'h1);
    rd(spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL, v); check(v, 8'h00);
    rd(spreading_code_config_pkg::ADDR_SPREADING_CONFIG, v); check(v, 8'h00);
    rd(spreading_code_config_pkg::ADDR_SYNTH_SETTLE_COUNT, v); check(v, 8'h64);
    rd(spreading_code_config_pkg::ADDR_SPREADING_CODE_LO, v); check(v, 8'h22);
    // reserved bits read back zero, unmapped place holds nothing
    wr_n(spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL, 64'h0003, 1);
    rd(spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL, v); check(v, 8'h00);
    wr_n(spreading_code_config_pkg::ADDR_SPREADING_CONFIG, 64'h00FC, 1);
    rd(spreading_code_config_pkg::ADDR_SPREADING_CONFIG, v); check(v, 8'h04);
    wr_n(6'h3A, 64'h005A, 1);
    rd(6'h3A, v); check(v, 8'h00);
    // code bytes in little endian order, then one byte alone
    code = 64'h0123_4567_89AB_CDEF;
    wr_n(spreading_code_config_pkg::ADDR_SPREADING_CODE_LO, code, 8);
    check(code_full, code);
    wr_n(6'h15, 64'h005A, 1);
    code[39:32] = 8'h5A;
    check(code_full, code);
    rd(spreading_code_config_pkg::ADDR_SPREADING_CODE_HI, v); check(v, 8'h01);
    // every config code with both half selects, in one burst each
    for (int k = 0; k < 16; k++) begin
      cfg = {5'h00, k[2:0]};
      wr_n(spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL, {48'h0, cfg, 2'b00, k[3], 5'h00}, 2);
      sel_hi = cfg[2] & ~cfg[1] & k[3];
      check(chips_32, cfg[2]);
      check(double_rate, cfg[2] & cfg[1]);
      check(bits_per_period, (cfg[2] & cfg[1]) ? 2'h2 : 2'h1);
      check(oversample_12x, cfg[2] & ~cfg[1] & cfg[0]);
      check(code_a, sel_hi ? code[63:32] : code[31:0]);
      check(code_b, sel_hi ? code[31:0] : code[63:32]);
    end
    // consistent 32-chip normal rate setting before the radio is started
    wr_n(spreading_code_config_pkg::ADDR_SPREADING_CONFIG, 64'h0005, 1);
    check(oversample_12x, 1'b1);
    check(chips_32, 1'b1);
    // bypassed lock: two settle units only
    synth_lock <= 1'b0;
    wr_n(spreading_code_config_pkg::ADDR_SYNTH_SETTLE_COUNT, 64'h0002, 1);
    wr_n(spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL, 64'h0050, 1);
    wait_rel(n);
    check(n >= 170 && n <= 230, 1'b1);
    repeat (3) @(posedge mclk);
    check(amp_enable, 1'b1);
    check(tx_enable, 1'b1);
    check(rx_enable, 1'b0);
    wr_n(spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL, 64'h0058, 1);
    check(amp_enable, 1'b0);
    wr_n(spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL, 64'h000C, 1);
    check(amp_enable, 1'b1);
    check(path_release, 1'b0);
    wr_n(spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL, 64'h0004, 1);
    check(amp_enable, 1'b0);
    // lock used: nothing until lock, then 25 settle units
    wr_n(spreading_code_config_pkg::ADDR_SYNTH_SETTLE_COUNT, 64'h0019, 1);
    wr_n(spreading_code_config_pkg::ADDR_RADIO_MODE_CONTROL, 64'h0080, 1);
    repeat (300) @(posedge mclk);
    check(path_release, 1'b0);
    synth_lock <= 1'b1;
    wait_rel(n);
    check(n >= 2490 && n <= 2560, 1'b1);
    check(rx_enable, 1'b1);
    give_verdict();
  end
endmodule : spreading_code_config_tb_top
`default_nettype wire
